// ===== logic/cpc_clock_control.sv
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - With main clock off, only clock control and PLL registers accept writes.
// - PLL clock is gated by the main clock enable.
// - After main enable, parameter writes blocked until processor clock on.
// - Denominator is high byte at 0x0001, low at 0x0002, reset zero.
// - Numerator is high byte at 0x0003, low at 0x0004, reset zero.
// - Integer factor bits 6:3 give 2 to 8; codes 0, 1 and 9 to 15 reserved.
// - Pre-divider bits 2:1 divide by 1 to 4; bit 0 fractional.
// - Read-only lock flag in bit 0 at 0x0006, reset zero.
// - Clock output rate applies only in shared pin clock output mode.
// - Clock output codes pick x2, x1, /2, /4, /8; 111 is off.
// - Clock output rate derives from a fixed 12.288 MHz master clock.
// - Times one and times two selections fail while PDM is enabled.
// - Regulator bit 2 powers the regulator down, reset zero.
// - Regulator bits 1:0 give 1.2 V or 1.1 V; others reserved.
// - PLL output active only with PLL enable and main enable set.
module cpc_clock_control #(
    parameter int ADDR_W = 8,
    parameter int LOCK_CYCLES = cpc_pkg::LOCK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Neighbouring state
    input wire logic processor_clock_enable_i,
    input wire logic shared_serial_data_pin_clock_mode_i,
    input wire logic density_modulated_output_enable_i,
    // Clock controls
    output logic main_clock_enable_o,
    output logic main_clock_source_select_o,
    output logic master_clock_div1_o,
    output logic core_clock_div1_o,
    output logic crystal_disable_o,
    output logic spike_filter_disable_o,
    output logic pll_powerdown_o,
    output logic pll_clock_enable_o,
    output logic pll_locked_o,
    output cpc_pkg::cpc_pll_cfg_t pll_cfg_o,
    // Write gating for other registers
    output logic other_register_write_enable_o,
    output logic parameter_write_enable_o,
    // Clock output pin
    output cpc_pkg::cpc_clock_output_pin_t clock_output_rate_o,
    // Regulator
    output logic regulator_powerdown_o,
    output logic [1:0] regulator_voltage_select_o,
    output logic regulator_voltage_valid_o
);

    logic [7:0] clk_control_q;
    logic [7:0] den_high_q;
    logic [7:0] den_low_q;
    logic [7:0] num_high_q;
    logic [7:0] num_low_q;
    logic [7:0] int_div_type_q;
    logic [7:0] clock_output_select_q;
    logic [7:0] regulator_q;
    logic ack_q;
    logic [31:0] rdata_q;
    cpc_pkg::cpc_lock_state_t lock_state_q;
    logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_q;

    logic [5:0] idx;
    logic req;
    logic wr;
    logic wr_allowed;
    logic main_en;
    logic pll_en;
    logic [3:0] mul_code;
    logic mul_valid;
    logic [7:0] rbyte;

    assign idx = wb_adr_i[ADDR_W-1:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign main_en = clk_control_q[cpc_pkg::CC_MAIN_EN];
    assign pll_en = clk_control_q[cpc_pkg::CC_PLL_EN];
    // Writes outside the clock group need the main clock
    assign wr_allowed = main_en || (idx <= cpc_pkg::IDX_LAST_PLL);
    assign wr = req && wb_we_i && wb_sel_i[0] && wr_allowed;
    assign mul_code = int_div_type_q[cpc_pkg::PT_MUL_LO +: 4];
    // Reserved factor codes leave the loop unable to lock
    assign mul_valid = (mul_code >= cpc_pkg::MUL_MIN)
        && (mul_code <= cpc_pkg::MUL_MAX);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_control_q <= cpc_pkg::RST_CLK_CONTROL;
        end else if (wr && idx == cpc_pkg::IDX_CLK_CONTROL) begin
            clk_control_q <= wb_dat_i[7:0] & cpc_pkg::CC_WMASK;
        end
    end

    // Ratio bytes are not locked against a running PLL; software's duty
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            den_high_q <= cpc_pkg::RST_BYTE;
            den_low_q <= cpc_pkg::RST_BYTE;
            num_high_q <= cpc_pkg::RST_BYTE;
            num_low_q <= cpc_pkg::RST_BYTE;
            int_div_type_q <= cpc_pkg::RST_BYTE;
        end else if (wr) begin
            case (idx)
                cpc_pkg::IDX_DEN_HIGH: begin
                    den_high_q <= wb_dat_i[7:0];
                end
                cpc_pkg::IDX_DEN_LOW: begin
                    den_low_q <= wb_dat_i[7:0];
                end
                cpc_pkg::IDX_NUM_HIGH: begin
                    num_high_q <= wb_dat_i[7:0];
                end
                cpc_pkg::IDX_NUM_LOW: begin
                    num_low_q <= wb_dat_i[7:0];
                end
                cpc_pkg::IDX_INT_DIV_TYPE: begin
                    int_div_type_q <= wb_dat_i[7:0] & cpc_pkg::PT_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_output_select_q <= cpc_pkg::RST_BYTE;
            regulator_q <= cpc_pkg::RST_BYTE;
        end else if (wr && idx == cpc_pkg::IDX_CLOCK_OUTPUT_SELECT) begin
            clock_output_select_q <= wb_dat_i[7:0] & cpc_pkg::CO_WMASK;
        end else if (wr && idx == cpc_pkg::IDX_REGULATOR) begin
            regulator_q <= wb_dat_i[7:0] & cpc_pkg::RG_WMASK;
        end
    end

    // Lock model: loop acquires while powered with a legal factor
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_state_q <= cpc_pkg::CPC_LK_OFF;
            lock_cnt_q <= '0;
        end else begin
            case (lock_state_q)
                cpc_pkg::CPC_LK_OFF: begin
                    lock_cnt_q <= '0;
                    if (pll_en && mul_valid) begin
                        lock_state_q <= cpc_pkg::CPC_LK_ACQ;
                    end
                end
                cpc_pkg::CPC_LK_ACQ: begin
                    if (!pll_en || !mul_valid) begin
                        lock_state_q <= cpc_pkg::CPC_LK_OFF;
                    end else if (lock_cnt_q == LOCK_CYCLES[$bits(lock_cnt_q)-1:0]
                        - 1'b1) begin
                        lock_state_q <= cpc_pkg::CPC_LK_LOCKED;
                    end else begin
                        lock_cnt_q <= lock_cnt_q + 1'b1;
                    end
                end
                cpc_pkg::CPC_LK_LOCKED: begin
                    if (!pll_en || !mul_valid) begin
                        lock_state_q <= cpc_pkg::CPC_LK_OFF;
                    end
                end
                default: begin
                    lock_state_q <= cpc_pkg::CPC_LK_OFF;
                end
            endcase
        end
    end

    always_comb begin
        rbyte = 8'h00;
        case (idx)
            cpc_pkg::IDX_CLK_CONTROL: rbyte = clk_control_q;
            cpc_pkg::IDX_DEN_HIGH: rbyte = den_high_q;
            cpc_pkg::IDX_DEN_LOW: rbyte = den_low_q;
            cpc_pkg::IDX_NUM_HIGH: rbyte = num_high_q;
            cpc_pkg::IDX_NUM_LOW: rbyte = num_low_q;
            cpc_pkg::IDX_INT_DIV_TYPE: rbyte = int_div_type_q;
            cpc_pkg::IDX_LOCK_STATUS: begin
                rbyte = {7'h00, lock_state_q == cpc_pkg::CPC_LK_LOCKED};
            end
            cpc_pkg::IDX_CLOCK_OUTPUT_SELECT: rbyte = clock_output_select_q;
            cpc_pkg::IDX_REGULATOR: rbyte = regulator_q;
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdata_q <= {24'h000000, rbyte};
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Clock controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_clock_enable_o <= 1'b0;
            main_clock_source_select_o <= 1'b0;
            master_clock_div1_o <= 1'b0;
            core_clock_div1_o <= 1'b0;
            crystal_disable_o <= 1'b0;
            spike_filter_disable_o <= 1'b0;
            pll_powerdown_o <= 1'b1;
            pll_clock_enable_o <= 1'b0;
            pll_locked_o <= 1'b0;
        end else begin
            main_clock_enable_o <= main_en;
            main_clock_source_select_o <= clk_control_q[cpc_pkg::CC_SRC];
            master_clock_div1_o <= clk_control_q[cpc_pkg::CC_MDIV];
            core_clock_div1_o <= clk_control_q[cpc_pkg::CC_CDIV];
            crystal_disable_o <= clk_control_q[cpc_pkg::CC_XTAL_DIS];
            spike_filter_disable_o <= clk_control_q[cpc_pkg::CC_SPIKE_DIS];
            pll_powerdown_o <= !pll_en;
            pll_clock_enable_o <= pll_en && main_en;
            pll_locked_o <= lock_state_q == cpc_pkg::CPC_LK_LOCKED;
        end
    end

    // PLL ratio as seen by the analog loop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_cfg_o <= '0;
        end else begin
            pll_cfg_o.multiplier <= mul_valid ? mul_code : 4'h0;
            pll_cfg_o.predivide <= {1'b0,
                int_div_type_q[cpc_pkg::PT_DIV_LO +: 2]} + 3'h1;
            pll_cfg_o.fractional <= int_div_type_q[cpc_pkg::PT_TYPE];
            // Integer mode hides the fraction entirely
            if (int_div_type_q[cpc_pkg::PT_TYPE]) begin
                pll_cfg_o.numerator <= {num_high_q, num_low_q};
                pll_cfg_o.denominator <= {den_high_q, den_low_q};
            end else begin
                pll_cfg_o.numerator <= 16'h0000;
                pll_cfg_o.denominator <= 16'h0000;
            end
        end
    end

    // Write gates for registers held elsewhere
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            other_register_write_enable_o <= 1'b0;
            parameter_write_enable_o <= 1'b0;
        end else begin
            other_register_write_enable_o <= main_en;
            parameter_write_enable_o <= main_en
                && processor_clock_enable_i;
        end
    end

    // Clock output rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_output_rate_o <= '0;
        end else begin
            clock_output_rate_o.code <= clock_output_select_q[2:0];
            clock_output_rate_o.enable <= 1'b0;
            clock_output_rate_o.rate_khz <= 16'h0000;
            // Pin not in clock mode: setting has no effect
            if (shared_serial_data_pin_clock_mode_i) begin
                case (clock_output_select_q[2:0])
                    cpc_pkg::CO_X2: begin
                        // Fast modes unusable beside PDM
                        if (!density_modulated_output_enable_i) begin
                            clock_output_rate_o.enable <= 1'b1;
                            clock_output_rate_o.rate_khz <=
                                {cpc_pkg::MCLK_KHZ[14:0], 1'b0};
                        end
                    end
                    cpc_pkg::CO_X1: begin
                        if (!density_modulated_output_enable_i) begin
                            clock_output_rate_o.enable <= 1'b1;
                            clock_output_rate_o.rate_khz <=
                                cpc_pkg::MCLK_KHZ;
                        end
                    end
                    cpc_pkg::CO_D2: begin
                        clock_output_rate_o.enable <= 1'b1;
                        clock_output_rate_o.rate_khz <=
                            {1'b0, cpc_pkg::MCLK_KHZ[15:1]};
                    end
                    cpc_pkg::CO_D4: begin
                        clock_output_rate_o.enable <= 1'b1;
                        clock_output_rate_o.rate_khz <=
                            {2'b00, cpc_pkg::MCLK_KHZ[15:2]};
                    end
                    cpc_pkg::CO_D8: begin
                        clock_output_rate_o.enable <= 1'b1;
                        clock_output_rate_o.rate_khz <=
                            {3'b000, cpc_pkg::MCLK_KHZ[15:3]};
                    end
                    // Off code and undefined codes drive nothing
                    default: begin
                    end
                endcase
            end
        end
    end

    // Regulator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regulator_powerdown_o <= 1'b0;
            regulator_voltage_select_o <= cpc_pkg::RV_1V2;
            regulator_voltage_valid_o <= 1'b1;
        end else begin
            regulator_powerdown_o <= regulator_q[cpc_pkg::RG_PD];
            regulator_voltage_select_o <= regulator_q[1:0];
            regulator_voltage_valid_o <= regulator_q[1:0] == cpc_pkg::RV_1V2
                || regulator_q[1:0] == cpc_pkg::RV_1V1;
        end
    end

endmodule

// ===== logic/cpc_pkg.sv
package cpc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CLK_CONTROL = 6'h00;
    localparam logic [5:0] IDX_DEN_HIGH = 6'h01;
    localparam logic [5:0] IDX_DEN_LOW = 6'h02;
    localparam logic [5:0] IDX_NUM_HIGH = 6'h03;
    localparam logic [5:0] IDX_NUM_LOW = 6'h04;
    localparam logic [5:0] IDX_INT_DIV_TYPE = 6'h05;
    localparam logic [5:0] IDX_LOCK_STATUS = 6'h06;
    localparam logic [5:0] IDX_CLOCK_OUTPUT_SELECT = 6'h07;
    localparam logic [5:0] IDX_REGULATOR = 6'h08;
    // Highest index still writable while the main clock is off
    localparam logic [5:0] IDX_LAST_PLL = 6'h06;

    // Reset values
    localparam logic [7:0] RST_CLK_CONTROL = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Clock control fields
    localparam int CC_MAIN_EN = 0;
    localparam int CC_MDIV = 1;
    localparam int CC_CDIV = 2;
    localparam int CC_SRC = 3;
    localparam int CC_XTAL_DIS = 4;
    localparam int CC_SPIKE_DIS = 5;
    localparam int CC_PLL_EN = 7;
    localparam logic [7:0] CC_WMASK = 8'hBF;

    // Integer/divider/type fields
    localparam int PT_TYPE = 0;
    localparam int PT_DIV_LO = 1;
    localparam int PT_MUL_LO = 3;
    localparam logic [3:0] MUL_MIN = 4'h2;
    localparam logic [3:0] MUL_MAX = 4'h8;
    localparam logic [7:0] PT_WMASK = 8'h7F;

    // Clock output codes and rates
    localparam logic [2:0] CO_X2 = 3'h0;
    localparam logic [2:0] CO_X1 = 3'h1;
    localparam logic [2:0] CO_D2 = 3'h2;
    localparam logic [2:0] CO_D4 = 3'h3;
    localparam logic [2:0] CO_D8 = 3'h4;
    localparam logic [2:0] CO_OFF = 3'h7;
    localparam logic [7:0] CO_WMASK = 8'h07;
    localparam logic [15:0] MCLK_KHZ = 16'h3000;

    // Regulator fields
    localparam int RG_PD = 2;
    localparam logic [1:0] RV_1V2 = 2'h0;
    localparam logic [1:0] RV_1V1 = 2'h1;
    localparam logic [7:0] RG_WMASK = 8'h07;

    // Lock acquisition time
    localparam int LOCK_TIME_NS = 10000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        CPC_LK_OFF = 3'h1,
        CPC_LK_ACQ = 3'h2,
        CPC_LK_LOCKED = 3'h4
    } cpc_lock_state_t;

    typedef struct packed {
        logic [3:0] multiplier;
        logic [2:0] predivide;
        logic fractional;
        logic [15:0] numerator;
        logic [15:0] denominator;
    } cpc_pll_cfg_t;

    typedef struct packed {
        logic enable;
        logic [2:0] code;
        logic [15:0] rate_khz;
    } cpc_clock_output_pin_t;

endpackage

// ===== verif/cpc_clock_control_chk.sv
`timescale 1ns/1ps
module cpc_clock_control_chk #(
    parameter int LOCK_CYCLES = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Neighbouring state
    input wire logic processor_clock_enable_i,
    input wire logic shared_serial_data_pin_clock_mode_i,
    input wire logic density_modulated_output_enable_i,
    // Outputs watched
    input wire logic main_clock_enable_o,
    input wire logic pll_powerdown_o,
    input wire logic pll_clock_enable_o,
    input wire logic pll_locked_o,
    input wire cpc_pkg::cpc_pll_cfg_t pll_cfg_o,
    input wire logic other_register_write_enable_o,
    input wire logic parameter_write_enable_o,
    input wire cpc_pkg::cpc_clock_output_pin_t clock_output_rate_o,
    input wire logic [1:0] regulator_voltage_select_o,
    input wire logic regulator_voltage_valid_o
);
    // Saturates so a long powered run cannot wrap
    int lock_wait_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || pll_powerdown_o) begin
            lock_wait_q <= 0;
        end else if (lock_wait_q < 65535) begin
            lock_wait_q <= lock_wait_q + 1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence req_taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_once_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    ack_latency_a: assert property (req_taken_s |=> ack_once_s)
        else $error("bus answer late or too long");
    idle_data_a: assert property (wb_dat_o[31:8] == 24'h0
        && (wb_ack_o || wb_dat_o[7:0] == 8'h00))
        else $error("read data outside a read answer");
    pll_gate_a: assert property (pll_clock_enable_o ==
        (main_clock_enable_o && !pll_powerdown_o))
        else $error("pll clock gate wrong");
    write_gate_a: assert property (
        other_register_write_enable_o == main_clock_enable_o)
        else $error("other register write gate wrong");
    param_gate_a: assert property (parameter_write_enable_o ==
        (main_clock_enable_o && $past(processor_clock_enable_i)))
        else $error("parameter write gate wrong");
    lock_time_a: assert property (
        $rose(pll_locked_o) |-> lock_wait_q >= LOCK_CYCLES)
        else $error("lock flag rose too early");
    lock_drop_a: assert property (
        $rose(pll_powerdown_o) |-> ##[0:2] !pll_locked_o)
        else $error("lock flag kept after pll off");
    cfg_int_a: assert property (!pll_cfg_o.fractional |->
        pll_cfg_o.numerator == 16'h0 && pll_cfg_o.denominator == 16'h0)
        else $error("ratio passed in integer mode");
    mult_range_a: assert property (
        pll_cfg_o.multiplier inside {4'h0, [4'h2:4'h8]})
        else $error("multiplier out of range");
    clock_output_pin_mode_a: assert property (clock_output_rate_o.enable |->
        $past(shared_serial_data_pin_clock_mode_i))
        else $error("clock output outside clock mode");
    clock_output_pin_pdm_a: assert property (clock_output_rate_o.enable &&
        clock_output_rate_o.code inside {3'h0, 3'h1} |->
        !$past(density_modulated_output_enable_i))
        else $error("fast clock output with pdm on");
    reg_valid_a: assert property (regulator_voltage_valid_o ==
        (regulator_voltage_select_o inside {2'h0, 2'h1}))
        else $error("regulator code validity wrong");
endmodule

// ===== verif/cpc_clock_control_test.sv
`timescale 1ns/1ps
module cpc_clock_control_test;
    logic clk_i, rst_i, cyc, stb, we, ack, proc_en, pin_mode, pdm_en;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd, r, seed;
    logic main_en, src, mdiv, cdiv, xtal, spk, pll_pd, pll_ce, lock;
    logic other_we, param_we, regulator_powerdown, reg_ok, en;
    logic [1:0] reg_v;
    cpc_pkg::cpc_pll_cfg_t cfg;
    cpc_pkg::cpc_clock_output_pin_t clock_output_pin;
    logic [7:0] model [0:15];
    logic [15:0] rates [0:4];
    int n_fail, comparisons, i, m, n;

    cpc_clock_control #(.LOCK_CYCLES(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack),
        .processor_clock_enable_i(proc_en),
        .shared_serial_data_pin_clock_mode_i(pin_mode),
        .density_modulated_output_enable_i(pdm_en),
        .main_clock_enable_o(main_en), .main_clock_source_select_o(src),
        .master_clock_div1_o(mdiv), .core_clock_div1_o(cdiv),
        .crystal_disable_o(xtal), .spike_filter_disable_o(spk),
        .pll_powerdown_o(pll_pd), .pll_clock_enable_o(pll_ce),
        .pll_locked_o(lock), .pll_cfg_o(cfg),
        .other_register_write_enable_o(other_we),
        .parameter_write_enable_o(param_we), .clock_output_rate_o(clock_output_pin),
        .regulator_powerdown_o(regulator_powerdown), .regulator_voltage_select_o(reg_v),
        .regulator_voltage_valid_o(reg_ok));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] wmask(input int k);
        case (k)
            0: return cpc_pkg::CC_WMASK;
            1, 2, 3, 4: return 8'hFF;
            5: return cpc_pkg::PT_WMASK;
            7: return cpc_pkg::CO_WMASK;
            8: return cpc_pkg::RG_WMASK;
            default: return 8'h00;
        endcase
    endfunction

    // Integer mode hides the ratio, reserved factors read as zero
    function automatic logic [39:0] exp_cfg();
        logic [3:0] f;
        logic fr;
        f = model[5][6:3];
        fr = model[5][0];
        return {(f >= 4'h2 && f <= 4'h8) ? f : 4'h0,
            {1'b0, model[5][2:1]} + 3'h1, fr,
            fr ? {model[3], model[4]} : 16'h0,
            fr ? {model[1], model[2]} : 16'h0};
    endfunction

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] idx,
        input logic [7:0] d, input logic [3:0] s);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        sel <= s;
        wdat <= {r[31:8], d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = rdat;
        if (k >= 20) chk(1'b0, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (w && s[0] && idx <= 8 && idx != 6 && (idx < 6 || model[0][0]))
            model[idx[3:0]] = d & wmask(idx);
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        bus(1'b1, 6'(idx), d, 4'h1);
    endtask

    task automatic rdchk(input int idx);
        bus(1'b0, 6'(idx), 8'h00, 4'h1);
        chk(rd, {24'h0, model[idx % 16]});
    endtask

    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        stop_test();
    end

    initial begin
        {cyc, stb, we, proc_en, pin_mode, pdm_en} = 6'h00;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        r = 32'h0;
        seed = 32'd23;
        n_fail = 0;
        comparisons = 0;
        rates = '{16'h6000, 16'h3000, 16'h1800, 16'h0C00, 16'h0600};
        for (i = 0; i < 16; i++) model[i] = 8'h00;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 16; i++) rdchk(i == 15 ? 63 : i);
        chk({pll_pd, reg_ok, regulator_powerdown, main_en}, 4'hC);
        bus(1'b1, 6'h01, 8'h5A, 4'hE);
        rdchk(1);
        for (i = 1; i <= 8; i++) begin
            r = rnd();
            wr(i, r[7:0]);
        end
        for (i = 1; i <= 8; i++) rdchk(i);
        for (i = 0; i < 16; i++) begin
            r = rnd();
            wr(5, {1'b0, i[3:0], r[2:0]});
            chk(cfg, exp_cfg());
        end
        wr(5, 8'h21);
        wr(0, 8'h80);
        chk(pll_ce, 1'b0);
        n = 0;
        do begin
            bus(1'b0, 6'h06, 8'h00, 4'h1);
            n++;
        end while (rd[0] !== 1'b1 && n < 40);
        model[6] = 8'h01;
        rdchk(6);
        chk(lock, 1'b1);
        wr(0, 8'h81);
        chk({pll_ce, main_en, other_we, param_we}, 4'hE);
        proc_en <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(param_we, 1'b1);
        wr(0, 8'hFF);
        chk({spk, xtal, src, cdiv, mdiv}, 5'h1F);
        rdchk(0);
        wr(6, 8'h00);
        rdchk(6);
        for (i = 0; i < 8; i++) begin
            r = rnd();
            wr(7, {r[7:3], i[2:0]});
            rdchk(7);
            for (m = 0; m < 4; m++) begin
                pin_mode <= m[0];
                pdm_en <= m[1];
                repeat (2) @(posedge clk_i);
                en = m[0] && i <= 4 && !(m[1] && i <= 1);
                chk({clock_output_pin.enable, clock_output_pin.code}, {en, i[2:0]});
                chk(clock_output_pin.rate_khz, en ? rates[i%5] : 16'h0);
            end
        end
        for (i = 0; i < 8; i++) begin
            r = rnd();
            wr(8, {r[7:3], i[2:0]});
            chk({regulator_powerdown, reg_v, reg_ok}, {i[2:0], !i[1]});
            rdchk(8);
        end
        wr(0, 8'h01);
        repeat (3) @(posedge clk_i);
        chk({lock, pll_ce, pll_pd}, 3'h1);
        model[6] = 8'h00;
        rdchk(6);
        wr(0, 8'h00);
        wr(7, 8'h02);
        wr(8, 8'h04);
        rdchk(7);
        rdchk(8);
        chk(other_we, 1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 16; i++) model[i] = 8'h00;
        for (i = 0; i < 9; i++) rdchk(i);
        stop_test();
    end
endmodule

bind cpc_clock_control cpc_clock_control_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
    .processor_clock_enable_i, .shared_serial_data_pin_clock_mode_i,
    .density_modulated_output_enable_i, .main_clock_enable_o,
    .pll_powerdown_o, .pll_clock_enable_o, .pll_locked_o, .pll_cfg_o,
    .other_register_write_enable_o, .parameter_write_enable_o,
    .clock_output_rate_o, .regulator_voltage_select_o,
    .regulator_voltage_valid_o);
